// >>> rtl/sreg_pkg.sv
package sreg_pkg;
	// Register indices; printed offsets are not multiples of four, so byte address is index*4
	localparam logic [2:0] IDX_CTRL1 = 3'h0;
	localparam logic [2:0] IDX_CTRL2 = 3'h1;
	localparam logic [2:0] IDX_ICTRL = 3'h2;
	localparam logic [2:0] IDX_STATUS = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [2:0] IDX_POLY = 3'h5;
	localparam logic [2:0] IDX_RECEIVE_CRC_VALUE = 3'h6;
	localparam logic [2:0] IDX_TRANSMIT_CRC_VALUE = 3'h7;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h02;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_POLY = 8'h07;
	localparam logic [7:0] RST_CRC = 8'h00;
	// Status bit positions
	localparam int SB_BUSY = 7;
	localparam int SB_OVR = 6;
	localparam int SB_MODE_FAULT_FLAG = 5;
	localparam int SB_CRC_ERROR_FLAG = 4;
	localparam int SB_WAKE = 3;
	localparam int SB_TXE = 1;
	localparam int SB_RX_NOT_EMPTY_FLAG = 0;
	// Control one / control two / interrupt control bit positions
	localparam int CB_CRC_ENABLE = 5;
	localparam int CB_CPHA = 0;
	localparam int CB_MASTER = 2;
	localparam int IB_ERROR_IRQ_ENABLE = 5;
	localparam int IB_WAKEUP_IRQ_ENABLE = 4;
	localparam int IB_TXDMA = 1;
	localparam int IB_RXDMA = 0;
	localparam logic [7:0] ICTRL_MASK = 8'hF3;
	localparam logic [7:0] CTRL2_MASK = 8'hFF;
endpackage

// >>> rtl/serial_status_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
// Summary of operation
// - Busy flag follows engine activity, read only
// - Overrun and mode fault sticky until cleared
// - Set CRC error on received CRC mismatch
// - CRC error cleared only by writing 0
// - Wakeup set on first sampling edge halted, in slave mode only
// - Wakeup cleared by software writing 0
// - Empty and not-empty flags track buffers
// - Status resets to 0x02 at offset 3
// - Data write loads transmit buffer only
// - Data read returns receive buffer
// - Data register offset 4, reset 0x00
// - Polynomial register offset 5, reset 0x07
// - Receive CRC accumulates received bytes when enabled
// - Writing crc_enable one clears receive CRC
// - Transmit CRC accumulates sent bytes when enabled
// - Writing crc_enable one clears transmit CRC
// - CRC computed bitwise with current polynomial
// - crc_enable switches CRC calculation on/off
// - Error flags request interrupt when enabled
// - Wakeup flag requests interrupt when enabled
// - Transmit DMA request while transmit empty
module serial_status_regs
	import sreg_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic eng_busy, // Engine transfer in progress
	input wire logic ovr_set, // Overrun event pulse
	input wire logic mode_fault_flag_set, // Mode fault event pulse
	input wire logic rx_valid, // Received byte strobe
	input wire logic [7:0] rx_byte, // Received byte
	input wire logic rx_is_crc, // Received byte is the CRC byte
	input wire logic tx_take, // Engine takes transmit byte
	input wire logic tx_bit_valid, // Transmitted bit strobe
	input wire logic tx_bit, // Transmitted bit
	input wire logic rx_bit_valid, // Received bit strobe
	input wire logic rx_bit, // Received bit
	input wire logic halted, // Chip in halt, async source
	input wire logic sck_pin, // Serial clock pin, async
	output logic [7:0] tx_byte, // Pending transmit byte
	output logic [7:0] ctrl_one, // Control one to engine
	output logic [7:0] ctrl_two, // Control two to engine
	output logic crc_on, // CRC calculation enabled
	output logic err_irq, // Error interrupt request
	output logic wake_irq, // Wakeup interrupt request
	output logic tx_dma_req, // Transmit DMA request
	output logic rx_dma_req // Receive DMA request
);
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic [7:0] ictrl_r;
	logic [7:0] poly_r;
	logic [7:0] txbuf_r;
	logic [7:0] rxbuf_r;
	logic [7:0] receive_crc_value_r;
	logic [7:0] transmit_crc_value_r;
	logic busy_r;
	logic ovr_r;
	logic mode_fault_flag_r;
	logic crc_error_flag_r;
	logic wake_r;
	logic txe_r;
	logic rx_not_empty_flag_r;
	logic [1:0] sck_s_r;
	logic [1:0] halt_s_r;
	logic sck_prev_r;
	logic wake_armed_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic err_irq_r;
	logic wake_irq_r;
	logic txdma_r;
	logic rxdma_r;
	logic status_rd_seen_r;

	// One shift of the serial CRC, most significant bit first
	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din,
		input logic [7:0] poly);
		logic fb;
		fb = crc[7] ^ din;
		crc_step = fb ? ({crc[6:0], 1'b0} ^ poly) : {crc[6:0], 1'b0};
	endfunction

	// Only aligned words inside the eight-register window answer
	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:5] == 27'h0) && (a[1:0] == 2'b00);
	endfunction

	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic [2:0] idx;
	assign idx = paddr[4:2];
	assign mapped = addr_ok(paddr);
	// Single-cycle answer: pready rises in the access phase
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready_r && pwrite && mapped;
	assign rd_acc = psel && penable && pready_r && !pwrite && mapped;

	logic wr_status;
	logic wr_data;
	logic wr_crcen1;
	logic rd_data;
	assign wr_status = wr_acc && idx == IDX_STATUS;
	assign wr_data = wr_acc && idx == IDX_DATA;
	assign rd_data = rd_acc && idx == IDX_DATA;
	assign wr_crcen1 = wr_acc && idx == IDX_CTRL2 && pwdata[CB_CRC_ENABLE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !addr_ok(paddr);
		end
	end

	// Captured in setup so the word stands with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else begin
			if (setup && !pwrite) begin
				case (idx)
					IDX_CTRL1: prdata_r <= {24'h0, ctrl1_r};
					IDX_CTRL2: prdata_r <= {24'h0, ctrl2_r};
					IDX_ICTRL: prdata_r <= {24'h0, ictrl_r};
					IDX_STATUS: prdata_r <= {24'h0, busy_r, ovr_r, mode_fault_flag_r, crc_error_flag_r,
						wake_r, 1'b0, txe_r, rx_not_empty_flag_r};
					IDX_DATA: prdata_r <= {24'h0, rxbuf_r};
					IDX_POLY: prdata_r <= {24'h0, poly_r};
					IDX_RECEIVE_CRC_VALUE: prdata_r <= {24'h0, receive_crc_value_r};
					IDX_TRANSMIT_CRC_VALUE: prdata_r <= {24'h0, transmit_crc_value_r};
					default: prdata_r <= 32'h0;
				endcase
				if (!mapped) begin
					prdata_r <= 32'h0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_r <= RST_CTRL;
		end else if (wr_acc && idx == IDX_CTRL1) begin
			ctrl1_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl2_r <= RST_CTRL;
		end else if (wr_acc && idx == IDX_CTRL2) begin
			ctrl2_r <= pwdata[7:0] & CTRL2_MASK;
		end
	end

	// Reserved enable bits masked so they read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ictrl_r <= RST_CTRL;
		end else if (wr_acc && idx == IDX_ICTRL) begin
			ictrl_r <= pwdata[7:0] & ICTRL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poly_r <= RST_POLY;
		end else if (wr_acc && idx == IDX_POLY) begin
			poly_r <= pwdata[7:0];
		end
	end

	// Transmit buffer; receive side untouched by writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txbuf_r <= RST_DATA;
			txe_r <= 1'b1;
		end else if (wr_data) begin
			txbuf_r <= pwdata[7:0];
			txe_r <= 1'b0;
		end else if (tx_take) begin
			txe_r <= 1'b1;
		end
	end

	// Receive buffer; a new byte wins over a same-cycle read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxbuf_r <= RST_DATA;
			rx_not_empty_flag_r <= 1'b0;
		end else if (rx_valid && !rx_is_crc) begin
			rxbuf_r <= rx_byte;
			rx_not_empty_flag_r <= 1'b1;
		end else if (rd_data) begin
			rx_not_empty_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= eng_busy;
		end
	end

	// Clear sequence: status read, then data access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_rd_seen_r <= 1'b0;
		end else if (rd_acc) begin
			status_rd_seen_r <= (idx == IDX_STATUS);
		end else if (wr_acc) begin
			status_rd_seen_r <= 1'b0;
		end
	end

	logic seq_clear;
	assign seq_clear = status_rd_seen_r && (rd_data || wr_data);

	// Set has priority so an event during the clear sequence survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_r <= 1'b0;
		end else if (ovr_set) begin
			ovr_r <= 1'b1;
		end else if (seq_clear) begin
			ovr_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_fault_flag_r <= 1'b0;
		end else if (mode_fault_flag_set) begin
			mode_fault_flag_r <= 1'b1;
		end else if (seq_clear) begin
			mode_fault_flag_r <= 1'b0;
		end
	end

	logic crc_mismatch;
	assign crc_mismatch = rx_valid && rx_is_crc && ctrl2_r[CB_CRC_ENABLE] && (rx_byte != receive_crc_value_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_error_flag_r <= 1'b0;
		end else if (crc_mismatch) begin
			crc_error_flag_r <= 1'b1;
		end else if (wr_status && !pwdata[SB_CRC_ERROR_FLAG]) begin
			crc_error_flag_r <= 1'b0;
		end
	end

	// Halt and clock pin are foreign, so synchronise both
	// Reset level matches the idle pin, so no false edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s_r <= 2'b00;
			sck_prev_r <= 1'b0;
		end else begin
			sck_s_r <= {sck_s_r[0], sck_pin};
			sck_prev_r <= sck_s_r[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_s_r <= 2'b00;
		end else begin
			halt_s_r <= {halt_s_r[0], halted};
		end
	end

	// Sampling edge: first edge for phase 0, second for phase 1
	logic sck_edge;
	logic slave_halted;
	assign sck_edge = sck_s_r[1] != sck_prev_r;
	assign slave_halted = halt_s_r[1] && !ctrl1_r[CB_MASTER];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_armed_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			if (!slave_halted) begin
				wake_armed_r <= 1'b0;
			end else if (sck_edge) begin
				wake_armed_r <= 1'b1;
			end
			if (slave_halted && sck_edge && (!ctrl1_r[CB_CPHA] || wake_armed_r)) begin
				wake_r <= 1'b1;
			end else if (wr_status && !pwdata[SB_WAKE]) begin
				wake_r <= 1'b0;
			end
		end
	end

	// Accumulators restart on every write of crc_enable as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_crc_value_r <= RST_CRC;
		end else if (wr_crcen1) begin
			receive_crc_value_r <= RST_CRC;
		end else if (ctrl2_r[CB_CRC_ENABLE] && rx_bit_valid && !rx_is_crc) begin
			receive_crc_value_r <= crc_step(receive_crc_value_r, rx_bit, poly_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_crc_value_r <= RST_CRC;
		end else if (wr_crcen1) begin
			transmit_crc_value_r <= RST_CRC;
		end else if (ctrl2_r[CB_CRC_ENABLE] && tx_bit_valid) begin
			transmit_crc_value_r <= crc_step(transmit_crc_value_r, tx_bit, poly_r);
		end
	end

	// Requests are registered, so they trail the flags by a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_irq_r <= 1'b0;
		end else begin
			err_irq_r <= ictrl_r[IB_ERROR_IRQ_ENABLE] && (crc_error_flag_r || ovr_r || mode_fault_flag_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_irq_r <= 1'b0;
		end else begin
			wake_irq_r <= ictrl_r[IB_WAKEUP_IRQ_ENABLE] && wake_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txdma_r <= 1'b0;
		end else begin
			txdma_r <= ictrl_r[IB_TXDMA] && txe_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdma_r <= 1'b0;
		end else begin
			rxdma_r <= ictrl_r[IB_RXDMA] && rx_not_empty_flag_r;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_byte = txbuf_r;
	assign ctrl_one = ctrl1_r;
	assign ctrl_two = ctrl2_r;
	assign crc_on = ctrl2_r[CB_CRC_ENABLE];
	assign err_irq = err_irq_r;
	assign wake_irq = wake_irq_r;
	assign tx_dma_req = txdma_r;
	assign rx_dma_req = rxdma_r;
endmodule

// >>> testbench/serial_status_checker.sv
`timescale 1ns/1ns
module serial_status_checker
	import sreg_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [7:0] tx_byte, // Tx byte
	input wire logic crc_on, // CRC on
	input wire logic eng_busy // Busy in
);
	localparam logic [31:0] ST = {27'h0, IDX_STATUS, 2'h0};
	localparam logic [31:0] DA = {27'h0, IDX_DATA, 2'h0};
	localparam logic [31:0] C2 = {27'h0, IDX_CTRL2, 2'h0};
	logic wa;
	logic ra;
	assign wa = psel && penable && pready && pwrite;
	assign ra = psel && penable && pready && !pwrite && paddr == ST;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
		else $error("ready late");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("stray ready");
	a_error_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("bad error read");
	a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	a_data_to_tx: assert property (wa && paddr == DA |=> tx_byte == $past(pwdata[7:0]))
		else $error("tx byte wrong");
	a_reserved_bit_zero: assert property (ra |-> !prdata[2])
		else $error("bit 2 set");
	a_crc_enable_follow: assert property (wa && paddr == C2 |=> crc_on == $past(pwdata[5]))
		else $error("crc_on wrong");
	a_busy_shown: assert property (ra && $past(eng_busy, 2) |-> prdata[7])
		else $error("busy missing");
	a_idle_not_busy: assert property (ra && !$past(eng_busy, 2) |-> !prdata[7])
		else $error("busy stuck");
	c_data_write: cover property (wa && paddr == DA);
	c_unmapped: cover property (pready && pslverr);
	c_crc_frame: cover property (eng_busy && crc_on);
endmodule
bind serial_status_regs serial_status_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .tx_byte, .crc_on, .eng_busy);

// >>> testbench/serial_far_model.sv
`timescale 1ns/1ns
module serial_far_model (
	input wire logic pclk, // Clock
	output logic sck_pin, // Serial clock
	output logic eng_busy, // Frame on
	output logic rx_valid, // Byte strobe
	output logic [7:0] rx_byte, // Byte in
	output logic rx_bit_valid, // Bit strobe in
	output logic rx_bit, // Bit in
	output logic tx_bit_valid, // Bit strobe out
	output logic tx_bit, // Bit out
	output logic tx_take // Byte taken
);
	initial begin
		{sck_pin, eng_busy, rx_valid, rx_bit_valid, rx_bit, tx_bit_valid, tx_bit, tx_take} = '0;
		rx_byte = 8'h00;
	end
	// Clock still between frames; idle lines inverted
	task automatic frame(input logic [7:0] b);
		@(posedge pclk);
		eng_busy <= 1'h1;
		for (int i = 7; i >= 0; i--) begin
			repeat (4) @(posedge pclk);
			sck_pin <= 1'h1;
			rx_bit <= b[i];
			tx_bit <= ~b[i];
			rx_bit_valid <= 1'h1;
			tx_bit_valid <= 1'h1;
			@(posedge pclk);
			rx_bit_valid <= 1'h0;
			tx_bit_valid <= 1'h0;
			rx_bit <= ~b[i];
			tx_bit <= b[i];
			repeat (3) @(posedge pclk);
			sck_pin <= 1'h0;
		end
		rx_valid <= 1'h1;
		rx_byte <= b;
		tx_take <= 1'h1;
		@(posedge pclk);
		rx_valid <= 1'h0;
		rx_byte <= ~b;
		tx_take <= 1'h0;
		eng_busy <= 1'h0;
	endtask
endmodule

// >>> testbench/serial_status_regs_bench.sv
`timescale 1ns/1ns
module serial_status_regs_bench;
	import sreg_pkg::*;
	localparam logic [31:0] C1 = {27'h0, IDX_CTRL1, 2'h0};
	localparam logic [31:0] C2 = {27'h0, IDX_CTRL2, 2'h0};
	localparam logic [31:0] ST = {27'h0, IDX_STATUS, 2'h0};
	localparam logic [31:0] DA = {27'h0, IDX_DATA, 2'h0};
	localparam logic [31:0] PO = {27'h0, IDX_POLY, 2'h0};
	localparam logic [31:0] RX = {27'h0, IDX_RECEIVE_CRC_VALUE, 2'h0};
	localparam logic [31:0] TX = {27'h0, IDX_TRANSMIT_CRC_VALUE, 2'h0};
	logic pclk, presetn, psel, penable, pwrite, ovr_set, mode_fault_flag_set, rx_is_crc, halted;
	logic [31:0] paddr, pwdata, prdata, d;
	logic pready, pslverr, e, eng_busy, rx_valid, rx_bit_valid, rx_bit;
	logic tx_take, tx_bit_valid, tx_bit, sck_pin;
	logic [7:0] rx_byte, tx_byte;
	int fail_count = 0;
	int cmp_count = 0;
	serial_status_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .eng_busy, .ovr_set, .mode_fault_flag_set, .rx_valid, .rx_byte, .rx_is_crc,
		.tx_take, .tx_bit_valid, .tx_bit, .rx_bit_valid, .rx_bit, .halted, .sck_pin, .tx_byte,
		.ctrl_one(), .ctrl_two(), .crc_on(), .err_irq(), .wake_irq(), .tx_dma_req(), .rx_dma_req());
	serial_far_model eng (.pclk, .sck_pin, .eng_busy, .rx_valid, .rx_byte, .rx_bit_valid,
		.rx_bit, .tx_bit_valid, .tx_bit, .tx_take);
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	task automatic report_and_stop;
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			$display("Error t=%0t got %h exp %h", $time, g, x);
			fail_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			n++;
			if (n > 20) begin
				fail_count++;
				report_and_stop;
			end
			@(posedge pclk);
		end
		d = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		apb(1'h1, a, v);
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(d & m, x);
	endtask
	function automatic logic [31:0] crc8(input logic [7:0] b, input logic [7:0] p);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 7; i >= 0; i--) c = (c[7] ^ b[i]) ? ((c << 1) ^ p) : (c << 1);
		return {24'h0, c};
	endfunction
	task automatic t_reset;
		rc(ST, 32'hFF, 32'h02);
		rc(DA, 32'hFF, 32'h00);
		rc(PO, 32'hFF, 32'h07);
		rc(RX, 32'hFF, 32'h00);
		rc(TX, 32'hFF, 32'h00);
		rc(32'h20, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, e}, 32'h1);
	endtask
	task automatic t_data;
		wr(DA, 32'hA5);
		@(posedge pclk);
		chk({24'h0, tx_byte}, 32'hA5);
		rc(DA, 32'hFF, 32'h00);
		rc(ST, 32'h03, 32'h00);
	endtask
	task automatic t_crc;
		logic [7:0] c;
		c = crc8(8'h5A, 8'h1D);
		wr(PO, 32'h1D);
		wr(C2, 32'h20);
		fork
			eng.frame(8'h5A);
			begin
				repeat (12) @(posedge pclk);
				rc(ST, 32'h80, 32'h80);
			end
		join
		rc(ST, 32'h83, 32'h03);
		rc(RX, 32'hFF, {24'h0, c});
		rc(TX, 32'hFF, crc8(8'hA5, 8'h1D));
		rc(DA, 32'hFF, 32'h5A);
		rx_is_crc <= 1'h1;
		eng.frame(c);
		rc(ST, 32'h10, 32'h00);
		eng.frame(~c);
		rc(ST, 32'h10, 32'h10);
		rx_is_crc <= 1'h0;
		wr(ST, 32'h10);
		rc(ST, 32'h10, 32'h10);
		wr(ST, 32'h00);
		rc(ST, 32'h10, 32'h00);
		wr(C2, 32'h20);
		rc(RX, 32'hFF, 32'h00);
		rc(TX, 32'hFF, 32'h00);
		wr(C2, 32'h00);
		eng.frame(8'h5A);
		rc(RX, 32'hFF, 32'h00);
	endtask
	task automatic t_overrun;
		@(posedge pclk);
		ovr_set <= 1'h1;
		mode_fault_flag_set <= 1'h1;
		@(posedge pclk);
		ovr_set <= 1'h0;
		mode_fault_flag_set <= 1'h0;
		rc(ST, 32'h60, 32'h60);
		wr(C1, 32'h00);
		apb(1'h0, DA, 32'h0);
		rc(ST, 32'h60, 32'h60);
		apb(1'h0, DA, 32'h0);
		rc(ST, 32'h60, 32'h00);
	endtask
	task automatic t_wake;
		wr(C1, 32'h04);
		halted <= 1'h1;
		eng.frame(8'h3C);
		rc(ST, 32'h08, 32'h00);
		wr(C1, 32'h00);
		eng.frame(8'h3C);
		rc(ST, 32'h08, 32'h08);
		wr(ST, 32'h08);
		rc(ST, 32'h08, 32'h08);
		wr(ST, 32'h00);
		rc(ST, 32'h08, 32'h00);
		wr(C1, 32'h01);
		eng.frame(8'h3C);
		rc(ST, 32'h08, 32'h08);
		wr(ST, 32'h00);
		rc(ST, 32'h08, 32'h00);
		halted <= 1'h0;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, ovr_set, mode_fault_flag_set, rx_is_crc, halted} = 8'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_data;
		t_crc;
		t_overrun;
		t_wake;
		report_and_stop;
	end
endmodule
